// [core/fbss_params.svh]
// offsets, codes, addresses and counts of the flash service sequencer
`ifndef FBSS_PARAMS_SVH
`define FBSS_PARAMS_SVH
`define FBSS_OFF_CALL      12'h000
`define FBSS_OFF_ACC       12'h004
`define FBSS_OFF_IDX       12'h008
`define FBSS_OFF_SP        12'h00C
`define FBSS_OFF_STATUS    12'h010
`define FBSS_OFF_FADDR     12'h014
`define FBSS_OFF_FDATA     12'h018
`define FBSS_SRAM_WIN      2'h1
`define FBSS_FN_PROGRAM    8'h02
`define FBSS_FN_ERASE      8'h03
`define FBSS_FN_PROTECT    8'h04
`define FBSS_FN_FULL       8'h05
`define FBSS_FN_TABLE      8'h06
`define FBSS_ENTRY_KEY     8'h3A
`define FBSS_SP_OFFSET     8'h03
`define FBSS_A_ENTRY_KEY_SLOT        8'hF8
`define FBSS_A_STACK_KEY_SLOT        8'hF9
`define FBSS_A_BLOCK       8'hFA
`define FBSS_A_PTR         8'hFB
`define FBSS_A_CLOCK       8'hFC
`define FBSS_A_DELAY       8'hFE
`define FBSS_A_PROT_SRC    8'h80
`define FBSS_RC_OK         8'h00
`define FBSS_RC_PROT       8'h01
`define FBSS_ERASED        8'hFF
`define FBSS_LAST_BYTE     13'h003F
`define FBSS_LAST_TBL      13'h0007
`define FBSS_LAST_FLASH    13'h1FFF
`define FBSS_ALT_TABLE     3'h1
`define FBSS_IDX_TRIM      8'hFF
// revision id value is arbitrary
`define FBSS_REV_ID        16'h1E2D
`define FBSS_REV_COUNT     8'h00
`define FBSS_RESP_OKAY     2'h0
`define FBSS_RESP_SLVERR   2'h2
`endif

// [core/fbss_pkg.sv]
// types of the flash service sequencer
package fbss_pkg;
  typedef enum logic [2:0] {
    st_idle, st_check, st_delay, st_run, st_done, st_halt
  } fbss_state_t;
endpackage

// [core/fbss_sequencer.sv]
// flash service sequencer with axi4-lite register access
`timescale 1ns/100ps
`default_nettype none
`include "fbss_params.svh"

module fbss_sequencer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite write channels
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // status
  output logic             busy,
  output logic             halted
);
  import fbss_pkg::*;

  localparam logic [15:0] REV_ID = `FBSS_REV_ID;

  logic [7:0]  sram_mem  [0:255];
  logic [7:0]  flash_mem [0:8191];
  logic [7:0]  prot_mem  [0:63];

  fbss_state_t st_q;
  fbss_state_t st_d;
  logic [7:0]  acc_q;
  logic [7:0]  idx_q;
  logic [7:0]  sp_q;
  logic [7:0]  func_q;
  logic [7:0]  blk_q;
  logic [7:0]  ptr_q;
  logic [7:0]  clk_q;
  logic [7:0]  pulse_q;
  logic [12:0] cnt_q;
  logic [2:0]  phase_q;
  logic [12:0] faddr_q;
  logic        blocked_q;
  logic        awready_q;
  logic        bvalid_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  bresp_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        busy_q;
  logic        halted_q;
  logic [7:0]  prot_snap_q;

  // two-bit protection code of a block within its packed byte
  function automatic logic [1:0] prot_code(input logic [7:0] pbyte, input logic [1:0] sel);
    logic [7:0] sh;
    sh = pbyte >> {sel, 1'b0};
    return sh[1:0];
  endfunction

  // manufacturing table row contents, arbitrary
  function automatic logic [7:0] table_byte(input logic [5:0] i);
    return {2'h0, i} ^ 8'h5A;
  endfunction

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

  // bus decode
  wire        wr_hs     = awready_q && s_axi_awvalid && s_axi_wvalid;
  wire        rd_hs     = arready_q && s_axi_arvalid;
  wire        wr_lane   = wr_hs && s_axi_wstrb[0];
  wire        w_sram    = s_axi_awaddr[11:10] == `FBSS_SRAM_WIN;
  wire        idle      = st_q == st_idle;
  wire        call_req  = wr_lane && is_reg(s_axi_awaddr, `FBSS_OFF_CALL) && s_axi_wdata[0] && idle;
  wire        w_acc     = wr_lane && is_reg(s_axi_awaddr, `FBSS_OFF_ACC) && idle;
  wire        w_sp      = wr_lane && is_reg(s_axi_awaddr, `FBSS_OFF_SP) && idle;
  wire        w_faddr   = wr_lane && is_reg(s_axi_awaddr, `FBSS_OFF_FADDR);
  wire        w_sram_ok = wr_lane && w_sram && idle;
  wire        w_mapped  = w_sram || is_reg(s_axi_awaddr, `FBSS_OFF_CALL)
                       || is_reg(s_axi_awaddr, `FBSS_OFF_ACC) || is_reg(s_axi_awaddr, `FBSS_OFF_SP)
                       || is_reg(s_axi_awaddr, `FBSS_OFF_FADDR);

  // parameter block checks
  wire [7:0]  entry_key_slot      = sram_mem[`FBSS_A_ENTRY_KEY_SLOT];
  wire [7:0]  stack_key_slot      = sram_mem[`FBSS_A_STACK_KEY_SLOT];
  wire [7:0]  blk_par   = sram_mem[`FBSS_A_BLOCK];
  wire        key_ok    = entry_key_slot == `FBSS_ENTRY_KEY && stack_key_slot == 8'(sp_q + `FBSS_SP_OFFSET);
  wire        is_prog   = func_q == `FBSS_FN_PROGRAM;
  wire        is_erase  = func_q == `FBSS_FN_ERASE;
  wire        is_prot   = func_q == `FBSS_FN_PROTECT;
  wire        is_full   = func_q == `FBSS_FN_FULL;
  wire        is_table  = func_q == `FBSS_FN_TABLE;
  wire        code_ok   = is_prog || is_erase || is_prot || is_full || is_table;
  wire [1:0]  blk_code  = prot_code(prot_mem[blk_par[7:2]], blk_par[1:0]);
  wire        blocked   = (is_prog || is_erase) && blk_code[1];
  wire        alt_tbl   = blk_q[2:0] == `FBSS_ALT_TABLE;

  // step engine
  wire        fire      = st_q == st_run && pulse_q == 8'h00;
  wire [12:0] last_cnt  = is_table ? `FBSS_LAST_TBL
                        : (is_full && phase_q < 3'h3) ? `FBSS_LAST_FLASH : `FBSS_LAST_BYTE;
  wire        at_last   = cnt_q == last_cnt;
  wire        run_end   = fire && at_last && (!is_full || phase_q == 3'h4);
  wire [12:0] blk_addr  = {blk_q[6:0], cnt_q[5:0]};
  wire [12:0] down_addr = ~cnt_q;
  wire [7:0]  src_byte  = sram_mem[8'(ptr_q + {2'h0, cnt_q[5:0]})];
  wire [7:0]  prot_src  = sram_mem[8'(`FBSS_A_PROT_SRC + {2'h0, cnt_q[5:0]})];
  wire [7:0]  prot_old  = prot_mem[cnt_q[5:0]];
  wire        prot_wr   = fire && (is_prot || (is_full && phase_q >= 3'h3));
  wire [7:0]  prot_new  = is_prot ? (prot_old | prot_src)
                        : (phase_q == 3'h3 ? `FBSS_ERASED : 8'h00);
  wire        tbl_wr    = fire && is_table;
  wire [7:0]  tbl_dst   = 8'(`FBSS_A_ENTRY_KEY_SLOT + {5'h00, cnt_q[2:0]});
  wire [7:0]  tbl_data  = table_byte({blk_q[2:0], cnt_q[2:0]});
  wire        done_rc   = st_q == st_done && !is_table;

  // register read mux
  wire [7:0]  rd_sram   = sram_mem[s_axi_araddr[9:2]];
  wire        r_sram    = s_axi_araddr[11:10] == `FBSS_SRAM_WIN;
  wire        r_status  = is_reg(s_axi_araddr, `FBSS_OFF_STATUS);
  wire [31:0] rd_word   = r_sram ? {24'h0, rd_sram}
    : is_reg(s_axi_araddr, `FBSS_OFF_CALL)  ? {31'h0, busy_q}
    : is_reg(s_axi_araddr, `FBSS_OFF_ACC)   ? {24'h0, acc_q}
    : is_reg(s_axi_araddr, `FBSS_OFF_IDX)   ? {24'h0, idx_q}
    : is_reg(s_axi_araddr, `FBSS_OFF_SP)    ? {24'h0, sp_q}
    : r_status ? {29'h0, blocked_q, halted_q, busy_q}
    : is_reg(s_axi_araddr, `FBSS_OFF_FADDR) ? {19'h0, faddr_q}
    : {24'h0, flash_mem[faddr_q]};
  wire        r_mapped  = r_sram || r_status || is_reg(s_axi_araddr, `FBSS_OFF_CALL)
    || is_reg(s_axi_araddr, `FBSS_OFF_ACC) || is_reg(s_axi_araddr, `FBSS_OFF_IDX)
    || is_reg(s_axi_araddr, `FBSS_OFF_SP) || is_reg(s_axi_araddr, `FBSS_OFF_FADDR)
    || is_reg(s_axi_araddr, `FBSS_OFF_FDATA);

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      st_idle:  if (call_req) st_d = st_check;
      st_check: begin
        if (!key_ok || !code_ok) begin
          st_d = st_halt;
        end else if (blocked) begin
          st_d = st_done;
        end else if (is_table) begin
          st_d = st_run;
        end else begin
          st_d = st_delay;
        end
      end
      st_delay: if (pulse_q == 8'h00) st_d = st_run;
      st_run:   if (run_end) st_d = st_done;
      st_done:  st_d = st_idle;
      st_halt:  st_d = st_halt;
      default:  st_d = st_idle;
    endcase
  end

  // axi handshakes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `FBSS_RESP_OKAY;
    end else begin
      awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
      if (wr_hs) begin
        bvalid_q <= 1'b1;
        bresp_q  <= w_mapped ? `FBSS_RESP_OKAY : `FBSS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `FBSS_RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else begin
      arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
      if (rd_hs) begin
        rvalid_q <= 1'b1;
        rdata_q  <= r_mapped ? rd_word : 32'h00000000;
        rresp_q  <= r_mapped ? `FBSS_RESP_OKAY : `FBSS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // sequencer control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q      <= st_idle;
      func_q    <= 8'h00;
      blk_q     <= 8'h00;
      ptr_q     <= 8'h00;
      clk_q     <= 8'h00;
      blocked_q <= 1'b0;
      busy_q    <= 1'b0;
      halted_q  <= 1'b0;
      prot_snap_q <= 8'h00;
    end else begin
      st_q <= st_d;
      busy_q   <= st_d != st_idle && st_d != st_halt;
      halted_q <= st_d == st_halt;
      if (call_req) func_q <= acc_q;
      if (st_q == st_check) begin
        blk_q     <= blk_par;
        ptr_q     <= sram_mem[`FBSS_A_PTR];
        clk_q     <= is_table ? 8'h00 : sram_mem[`FBSS_A_CLOCK];
        blocked_q <= blocked;
        prot_snap_q <= prot_mem[blk_par[7:2]];
      end
    end
  end

  // pulse width, delay and step counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_q <= 8'h00;
      cnt_q   <= 13'h0000;
      phase_q <= 3'h0;
    end else if (st_q == st_check) begin
      pulse_q <= is_table ? 8'h00 : sram_mem[`FBSS_A_DELAY];
      cnt_q   <= 13'h0000;
      phase_q <= is_full ? 3'h0 : 3'h4;
    end else if (st_q == st_delay && pulse_q == 8'h00) begin
      pulse_q <= clk_q;
    end else if (fire) begin
      pulse_q <= clk_q;
      cnt_q   <= at_last ? 13'h0000 : 13'(cnt_q + 13'h0001);
      if (at_last && phase_q != 3'h4) phase_q <= 3'(phase_q + 3'h1);
    end else if (pulse_q != 8'h00) begin
      pulse_q <= 8'(pulse_q - 8'h01);
    end
  end

  // accumulator, index and stack pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q   <= 8'h00;
      idx_q   <= 8'h00;
      sp_q    <= 8'h00;
      faddr_q <= 13'h0000;
    end else begin
      if (w_acc) acc_q <= s_axi_wdata[7:0];
      if (w_sp) sp_q <= s_axi_wdata[7:0];
      if (w_faddr) faddr_q <= s_axi_wdata[12:0];
      if (st_q == st_done && is_table) begin
        acc_q <= alt_tbl ? `FBSS_REV_COUNT : REV_ID[7:0];
        idx_q <= alt_tbl ? `FBSS_IDX_TRIM : REV_ID[15:8];
      end else if (st_q == st_done) begin
        acc_q <= 8'h00;
      end
    end
  end

  // parameter sram
  always_ff @(posedge clk) begin
    if (w_sram_ok) sram_mem[s_axi_awaddr[9:2]] <= s_axi_wdata[7:0];
    if (tbl_wr) sram_mem[tbl_dst] <= tbl_data;
    if (done_rc) begin
      sram_mem[`FBSS_A_ENTRY_KEY_SLOT] <= blocked_q ? `FBSS_RC_PROT : `FBSS_RC_OK;
      sram_mem[`FBSS_A_STACK_KEY_SLOT] <= 8'h00;
    end
  end

  // user flash, hidden blocks live outside this array
  always_ff @(posedge clk) begin
    if (fire && is_prog) flash_mem[blk_addr] <= src_byte;
    if (fire && is_erase) flash_mem[blk_addr] <= `FBSS_ERASED;
    if (fire && is_full && phase_q < 3'h3) begin
      flash_mem[down_addr] <= (phase_q == 3'h1) ? 8'h00 : `FBSS_ERASED;
    end
  end

  // protection block
  always_ff @(posedge clk) begin
    if (prot_wr) prot_mem[cnt_q[5:0]] <= prot_new;
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign busy          = busy_q;
  assign halted        = halted_q;

  property p_key_halt;
    @(posedge clk) disable iff (rst) (st_q == st_check && !key_ok) |=> (st_q == st_halt) [*2];
  endproperty
  a_key_halt: assert property (p_key_halt) else $error("bad key did not halt");

  property p_code_halt;
    @(posedge clk) disable iff (rst) (st_q == st_check && key_ok && !code_ok) |=> halted;
  endproperty
  a_code_halt: assert property (p_code_halt) else $error("bad code did not halt");

  property p_pulse;
    @(posedge clk) disable iff (rst)
      (fire && !run_end) |=> (pulse_q == clk_q && fire == (clk_q == 8'h00));
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width not from divider");

  property p_abort;
    @(posedge clk) disable iff (rst)
      (st_q == st_check && key_ok && blocked) |=> st_q == st_done ##1
      (sram_mem[`FBSS_A_ENTRY_KEY_SLOT] == `FBSS_RC_PROT && sram_mem[`FBSS_A_STACK_KEY_SLOT] == 8'h00 && acc_q == 8'h00);
  endproperty
  a_abort: assert property (p_abort) else $error("protected block not aborted");

  property p_no_lower;
    @(posedge clk) disable iff (rst) (prot_wr && !is_full) |-> ((prot_new & prot_old) == prot_old);
  endproperty
  a_no_lower: assert property (p_no_lower) else $error("protection lowered");

  property p_or;
    @(posedge clk) disable iff (rst)
      (fire && is_prot) |=> (prot_mem[$past(cnt_q[5:0])] == ($past(prot_old) | $past(prot_src)));
  endproperty
  a_or: assert property (p_or) else $error("protection merge wrong");

  property p_table;
    @(posedge clk) disable iff (rst) tbl_wr |=> sram_mem[$past(tbl_dst)] == $past(tbl_data);
  endproperty
  a_table: assert property (p_table) else $error("table byte misplaced");

  property p_alt;
    @(posedge clk) disable iff (rst)
      (st_q == st_done && is_table && alt_tbl) |=> (idx_q == `FBSS_IDX_TRIM && acc_q == `FBSS_REV_COUNT);
  endproperty
  a_alt: assert property (p_alt) else $error("trim table result wrong");

  property p_erase_keep;
    @(posedge clk) disable iff (rst)
      (st_q == st_done && is_erase) |-> prot_mem[blk_q[7:2]] == prot_snap_q;
  endproperty
  a_erase_keep: assert property (p_erase_keep) else $error("erase touched protection");

endmodule
`default_nettype wire

// [tb/fbss_cpu_model.sv]
// processor-side model issuing supervisory calls over axi4-lite
`timescale 1ns/100ps
`default_nettype none
`include "fbss_params.svh"
module fbss_cpu_model (
  // clock
  input  wire logic        clk,
  // write channels
  output var logic [11:0]  awaddr,
  output var logic         awvalid,
  input  wire logic        awready,
  output var logic [31:0]  wdata,
  output var logic [3:0]   wstrb,
  output var logic         wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var logic         bready,
  // read channels
  output var logic [11:0]  araddr,
  output var logic         arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var logic         rready
);
  localparam logic [7:0] SP_VAL = 8'h40;
  bit tmo = 1'b0;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  function automatic logic [11:0] sa(input logic [7:0] a);
    return 12'h400 + {2'h0, a, 2'h0};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit got;
    got = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64 && !got; n++) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        got = 1'b1;
        bready <= 1'b0;
      end
    end
    if (!got) tmo = 1'b1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit got;
    got = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64 && !got; n++) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        got = 1'b1;
        rready <= 1'b0;
      end
    end
    if (!got) tmo = 1'b1;
  endtask
  // parameter block, code, call, then poll busy
  task automatic call(input logic [7:0] code, input logic [7:0] blk, input logic [7:0] ptr,
                      input bit bad_key);
    logic [1:0]  r;
    logic [31:0] d;
    logic [7:0]  div;
    int          n;
    div = (code == `FBSS_FN_PROGRAM || code == `FBSS_FN_ERASE) ? {6'h0, 2'($urandom)} : 8'h00;
    wr(`FBSS_OFF_SP, {24'h0, SP_VAL}, r);
    wr(sa(`FBSS_A_ENTRY_KEY_SLOT), {24'h0, bad_key ? 8'h00 : `FBSS_ENTRY_KEY}, r);
    wr(sa(`FBSS_A_STACK_KEY_SLOT), {24'h0, SP_VAL + `FBSS_SP_OFFSET}, r);
    wr(sa(`FBSS_A_BLOCK), {24'h0, blk}, r);
    wr(sa(`FBSS_A_PTR), {24'h0, ptr}, r);
    wr(sa(`FBSS_A_CLOCK), {24'h0, div}, r);
    wr(sa(`FBSS_A_DELAY), 32'h56, r);
    wr(`FBSS_OFF_ACC, {24'h0, code}, r);
    wr(`FBSS_OFF_CALL, 32'h1, r);
    d = 32'h1;
    for (n = 0; n < 9000 && d[0] === 1'b1 && !tmo; n++) rd(`FBSS_OFF_STATUS, d, r);
    if (d[0] !== 1'b0) tmo = 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the flash service sequencer
`timescale 1ns/100ps
`default_nettype none
`include "fbss_params.svh"
module testbench;
  localparam logic [7:0]  PTR = 8'h10;
  localparam logic [15:0] REV = `FBSS_REV_ID;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, busy, halted;
  logic [7:0]  fm [8192];
  logic [1:0]  pm [256];
  int          failures = 0;
  int          num_checks = 0;
  always #25 clk = ~clk;
  fbss_sequencer u_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .busy(busy), .halted(halted)
  );
  fbss_cpu_model u_cpu (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang_check;
    if (u_cpu.tmo) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    u_cpu.rd(a, d, r);
    hang_check();
    chk_d(d, e);
  endtask
  task automatic sram_wr(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] r;
    u_cpu.wr(u_cpu.sa(a), {24'h0, v}, r);
    hang_check();
  endtask
  task automatic fl_chk(input logic [12:0] a, input logic [7:0] e);
    logic [1:0] r;
    u_cpu.wr(`FBSS_OFF_FADDR, {19'h0, a}, r);
    rd_chk(`FBSS_OFF_FDATA, {24'h0, e});
  endtask
  task automatic blk_chk(input logic [6:0] b);
    int k;
    for (k = 0; k < 64; k++) fl_chk({b, 6'(k)}, fm[{b, 6'(k)}]);
  endtask
  task automatic svc(input logic [7:0] code, input logic [7:0] blk, input logic [7:0] rc);
    u_cpu.call(code, blk, PTR, 1'b0);
    hang_check();
    rd_chk(u_cpu.sa(`FBSS_A_ENTRY_KEY_SLOT), {24'h0, rc});
    rd_chk(u_cpu.sa(`FBSS_A_STACK_KEY_SLOT), 32'h0);
    rd_chk(`FBSS_OFF_ACC, 32'h0);
    chk_d({31'h0, busy}, 32'h0);
  endtask
  task automatic prog(input logic [6:0] b);
    int         k;
    logic [7:0] v;
    logic [7:0] rc;
    rc = pm[b][1] ? `FBSS_RC_PROT : `FBSS_RC_OK;
    for (k = 0; k < 64; k++) begin
      v = 8'($urandom);
      sram_wr(PTR + 8'(k), v);
      if (rc == `FBSS_RC_OK) fm[{b, 6'(k)}] = v;
    end
    svc(`FBSS_FN_PROGRAM, {1'b0, b}, rc);
    blk_chk(b);
  endtask
  task automatic ers(input logic [6:0] b);
    int         k;
    logic [7:0] rc;
    rc = pm[b][1] ? `FBSS_RC_PROT : `FBSS_RC_OK;
    for (k = 0; k < 64; k++) if (rc == `FBSS_RC_OK) fm[{b, 6'(k)}] = `FBSS_ERASED;
    svc(`FBSS_FN_ERASE, {1'b0, b}, rc);
    blk_chk(b);
  endtask
  task automatic wipe(input logic [6:0] b);
    int k;
    ers(b);
    for (k = 0; k < 64; k++) begin
      sram_wr(PTR + 8'(k), 8'h00);
      fm[{b, 6'(k)}] = 8'h00;
    end
    svc(`FBSS_FN_PROGRAM, {1'b0, b}, `FBSS_RC_OK);
    blk_chk(b);
  endtask
  task automatic prot(input logic [5:0] b, input logic [7:0] v);
    int k;
    sram_wr(`FBSS_A_PROT_SRC + 8'(b), v);
    for (k = 0; k < 4; k++) pm[{b, 2'(k)}] = pm[{b, 2'(k)}] | v[2*k +: 2];
    svc(`FBSS_FN_PROTECT, 8'h00, `FBSS_RC_OK);
  endtask
  task automatic full;
    int k;
    for (k = 0; k < 8192; k++) fm[k] = `FBSS_ERASED;
    for (k = 0; k < 256; k++) pm[k] = 2'h0;
    svc(`FBSS_FN_FULL, 8'h00, `FBSS_RC_OK);
    for (k = 0; k < 8; k++) fl_chk(13'(k * 1031 + 5), `FBSS_ERASED);
  endtask
  initial begin
    int          i, j;
    logic [31:0] d;
    logic [1:0]  r;
    void'($urandom(32'h38075992));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 64; i++) sram_wr(`FBSS_A_PROT_SRC + 8'(i), 8'h00);
    full();
    prog(7'h7F);
    prog(7'h00);
    wipe(7'h01);
    ers(7'h7F);
    prog(7'h7F);
    prot(6'h1F, 8'hE4);
    for (j = 0; j < 4; j++) prog(7'h7C + 7'(j));
    ers(7'h7F);
    ers(7'h7D);
    prot(6'h1F, 8'h00);
    prog(7'h7E);
    blk_chk(7'h00);
    for (j = 0; j < 2; j++) begin
      u_cpu.call(`FBSS_FN_TABLE, 8'hF8 | 8'(j), PTR, 1'b0);
      hang_check();
      for (i = 0; i < 8; i++)
        rd_chk(u_cpu.sa(8'hF8 + 8'(i)), {24'h0, 8'(8 * j + i) ^ 8'h5A});
      rd_chk(`FBSS_OFF_ACC, {24'h0, j ? `FBSS_REV_COUNT : REV[7:0]});
      rd_chk(`FBSS_OFF_IDX, {24'h0, j ? `FBSS_IDX_TRIM : REV[15:8]});
    end
    u_cpu.rd(12'h020, d, r);
    hang_check();
    chk_d({30'h0, r}, {30'h0, `FBSS_RESP_SLVERR});
    chk_d(d, 32'h0);
    u_cpu.wr(12'h024, 32'h1, r);
    hang_check();
    chk_d({30'h0, r}, {30'h0, `FBSS_RESP_SLVERR});
    full();
    prog(7'h7F);
    u_cpu.call(`FBSS_FN_ERASE, 8'h00, PTR, 1'b1);
    hang_check();
    chk_d({31'h0, halted}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_d({31'h0, halted}, 32'h0);
    u_cpu.call(8'h09, 8'h00, PTR, 1'b0);
    hang_check();
    chk_d({31'h0, halted}, 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
